// [design/sbw_pkg.sv]
// shared constants and carrier types for the system bus write path
package sbw_pkg;
   // =========================================
   // command bus encoding
   localparam logic [8:0] CMD_WIDTH_DUMMY = 9'h000;
   localparam int CMD_KIND_BIT = 8;
   localparam logic [2:0] REQ_TYPE_WRITE = 3'h2;
   localparam logic [1:0] WR_ATTR_BLOCK = 2'h2;
   localparam logic [1:0] WR_ATTR_SINGLE = 2'h3;
   localparam logic [1:0] BLK_SIZE_8W = 2'h1;
   localparam logic [2:0] SIZE_WORD = 3'h3;
   // =========================================
   // sizes and timing counts
   localparam int BLOCK_DW = 4;
   localparam int BLOCK_W32 = 8;
   localparam int LEGACY_IDLE = 2;
   localparam int RDY_LEAD = 2;
   localparam int FIFO_DEPTH = 8;
   localparam logic [3:0] BEAT_ZERO = 4'h0;
   // =========================================
   // protocol modes, fixed at reset
   typedef enum logic [1:0] {SBW_LEGACY, SBW_REISSUE, SBW_PIPE} sbw_mode_e;
   // one write request from the core
   typedef struct packed {
      logic blk;           // cache line block write
      logic [63:0] addr;
      logic [2:0] size;    // bytes minus one for single writes
      logic keep_line;     // line retained after write back
      logic [255:0] line;  // block data, or data in low 64 bits
   } sbw_req_s;
   localparam int REQ_W = $bits(sbw_req_s);
   // one bus cycle as driven onto the pins
   typedef struct packed {
      logic [63:0] ad;
      logic [7:0] chk;
      logic [8:0] cmd;
   } sbw_beat_s;
endpackage : sbw_pkg

// [design/sbw_fifo.sv]
// parameterised valid/ready fifo in flip-flops
`timescale 1ns/10ps
module sbw_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // =========================================
   // honest full and empty flags
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   // storage write
   always_ff @(posedge ref_clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end
   // pointers wrap at depth
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : sbw_fifo

// [design/sbw_beat_gen.sv]
// builds address and data beats with check bits for one request
`timescale 1ns/10ps
module sbw_beat_gen
   import sbw_pkg::*;
(
   input wire logic bus32,
   input wire logic big_end,
   input wire sbw_req_s req,
   input wire logic [3:0] beat,      // 0 is address, then data beats
   input wire logic hi_half,         // second request of a split write
   output sbw_beat_s out_beat,
   output logic [3:0] last_beat
);
   // even parity per byte lane
   function automatic logic [7:0] chk8(input logic [63:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++)
         r[i] = ^v[i*8 +: 8];
      return r;
   endfunction : chk8
   wire logic [3:0] dsel = beat - 4'h1;
   wire logic [63:0] dw = req.line[dsel[1:0]*64 +: 64];
   wire logic [63:0] dw32 = req.line[dsel[2:1]*64 +: 64];
   // first word sent is low half in little endian
   wire logic first_hi = big_end;
   // a split single keeps the same word order as a block
   wire logic take_hi = req.blk ? (dsel[0] ^ first_hi) : ((req.size > SIZE_WORD) && (hi_half ^ first_hi));
   wire logic [31:0] word = take_hi ? (req.blk ? dw32[63:32] : req.line[63:32])
                                    : (req.blk ? dw32[31:0] : req.line[31:0]);
   wire logic [63:0] a64 = {req.addr[63:3], 3'h0};
   wire logic [31:0] a32 = {req.addr[31:3], hi_half, 2'h0};
   wire logic [63:0] ad_val = (beat == BEAT_ZERO) ? (bus32 ? {32'h0000_0000, a32} : a64)
                            : (bus32 ? {32'h0000_0000, word} : (req.blk ? dw : req.line[63:0]));
   wire logic [2:0] sz32 = (req.size > SIZE_WORD) ? (hi_half ? req.size - 3'h4 : SIZE_WORD) : req.size;
   wire logic [4:0] attr = req.blk ? {WR_ATTR_BLOCK, req.keep_line, BLK_SIZE_8W}
                                   : {WR_ATTR_SINGLE, bus32 ? sz32 : req.size};
   // =========================================
   // outputs: command in address cycle, data id with more-beats flag after
   assign last_beat = req.blk ? (bus32 ? 4'h8 : 4'h4) : 4'h1;
   assign out_beat.ad = ad_val;
   wire logic [7:0] chk_all = chk8(ad_val);
   assign out_beat.chk = bus32 ? {4'h0, chk_all[3:0]} : chk_all;
   assign out_beat.cmd = (beat == BEAT_ZERO) ? {1'b0, REQ_TYPE_WRITE, attr}
                       : {1'b1, (beat != last_beat), 7'h00};
endmodule : sbw_beat_gen

// [design/sbw_write_path.sv]
// system bus write path: request fifo, issue flow control, bus drive
`timescale 1ns/10ps
// What this block does
// - 64-bit block write: one address, four doublewords
// - 64-bit single write uses doubleword-aligned address
// - legacy mode: address, data, two idle
// - issue needs ready low two cycles before
// - reissue mode also needs ready at address
// - failed reissue repeats same address/data pair
// - pipelined mode drops the idle cycles
// - protocols govern single and block writes
// - 32-bit mode uses low lanes only
// - four check bits give even parity
// - low lanes used in either byte order
// - same command encoding, width not signalled
// - 32-bit block: one address, eight words
// - word order of doubleword follows endianness
// - 32-bit single write uses word-aligned address
// - wide uncached write split into two
// - bus width fixed at reset
// - command msb zero for command, one data
// - write command type code two
module sbw_write_path
   import sbw_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic cfg_bus32,
   input wire logic cfg_big_end,
   input wire logic [1:0] cfg_mode,
   input wire logic req_valid,
   output logic req_ready,
   input wire sbw_req_s req_data,
   input wire logic write_accept_ready_n,
   output logic [63:0] sys_addr_data_bus,
   output logic [7:0] sys_check_bits,
   output logic [8:0] sys_command_bus,
   output logic processor_drive_valid_n,
   output logic bus_oe_n,
   output logic write_done
);
   // =========================================
   // ready pin synchroniser and history
   logic wr_s1;
   logic wr_s2;
   logic [RDY_LEAD-1:0] wr_hist;
   // two flops tame the asynchronous pin; reset level means not ready
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         wr_s1 <= 1'b1;
         wr_s2 <= 1'b1;
      end
      else
      begin
         wr_s1 <= write_accept_ready_n;
         wr_s2 <= wr_s1;
      end
   end

   // history of the synchronised level, oldest at the top
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         wr_hist <= '1;
      else
         wr_hist <= {wr_hist[RDY_LEAD-2:0], wr_s2};
   end
   // ready as seen two cycles ago and now
   wire logic rdy_early = !wr_hist[RDY_LEAD-1];
   wire logic rdy_now = !wr_s2;

   // =========================================
   // configuration caught in the first cycle after reset
   logic cfg_taken;
   logic bus32;
   logic big_end;
   sbw_mode_e mode;
   // unused mode code falls back to the legacy spacing
   function automatic sbw_mode_e decode_mode(input logic [1:0] code);
      sbw_mode_e m;
      case (code)
         2'h1: m = SBW_REISSUE;
         2'h2: m = SBW_PIPE;
         default: m = SBW_LEGACY;
      endcase
      return m;
   endfunction : decode_mode

   wire sbw_mode_e cfg_mode_e = decode_mode(cfg_mode);
   // one-shot flag: configuration is not taken again until reset
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         cfg_taken <= 1'b0;
      else if (!cfg_taken)
         cfg_taken <= 1'b1;
   end
   // no reset needed here: nothing starts before the flag rises
   always_ff @(posedge ref_clk)
   begin
      if (!sys_rst && !cfg_taken)
      begin
         bus32 <= cfg_bus32;
         big_end <= cfg_big_end;
         mode <= cfg_mode_e;
      end
   end

   // =========================================
   // request buffer: stalls the core when full
   logic fifo_valid;
   logic fifo_pop;
   logic [REQ_W-1:0] fifo_data;
   sbw_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data(req_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );
   wire sbw_req_s head = sbw_req_s'(fifo_data);

   // requests held in the buffer; the head counts until its pop
   logic [3:0] queued;
   wire logic push_seen = req_valid && req_ready;
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         queued <= 4'h0;
      else
         queued <= queued + 4'(push_seen) - 4'(fifo_pop);
   end
   // another request stands behind the head being popped
   wire logic more_queued = (queued > 4'h1);

   // =========================================
   // sequencer state
   typedef enum logic [1:0] {SBW_IDLE, SBW_ADDR, SBW_DATA, SBW_GAP} sbw_state_e;
   sbw_state_e state;
   sbw_state_e next_state;
   logic [3:0] beat;
   logic [3:0] next_beat;
   logic hi_half;
   logic next_hi_half;
   logic [1:0] gap;
   logic [1:0] next_gap;
   // retry data cycle shows data beat one again
   localparam logic [3:0] RETRY_BEAT = 4'hF;
   localparam logic [3:0] FIRST_DATA = 4'h1;
   wire logic [3:0] show_beat = (beat == RETRY_BEAT) ? FIRST_DATA : beat;

   // beat builder for the head request
   sbw_beat_s cur_beat;
   logic [3:0] last_beat;
   sbw_beat_gen u_beat
   (
      .bus32(bus32),
      .big_end(big_end),
      .req(head),
      .beat(show_beat),
      .hi_half(hi_half),
      .out_beat(cur_beat),
      .last_beat(last_beat)
   );

   // a wide single write in 32-bit mode needs two requests
   wire logic split = bus32 && !head.blk && (head.size > SIZE_WORD);
   wire logic can_start = cfg_taken && fifo_valid && rdy_early;
   // in reissue mode the address cycle must also see ready
   wire logic addr_ok = (mode != SBW_REISSUE) || rdy_now;
   wire logic at_last = (beat == last_beat);
   wire logic req_end = (state == SBW_DATA) && at_last;
   wire logic whole_end = req_end && (!split || hi_half);
   // pipelined mode skips idle; reissue also runs back to back
   wire logic use_gap = (mode == SBW_LEGACY);
   // a following pair needs work pending and ready seen early enough
   function automatic logic pair_go(input logic pending, input logic rdy);
      return pending && rdy;
   endfunction : pair_go

   // =========================================
   // next-state decode
   always_comb
   begin
      next_state = state;
      next_beat = beat;
      next_hi_half = hi_half;
      next_gap = gap;
      case (state)
         SBW_IDLE:
         begin
            // wait for a queued request and early ready
            if (can_start)
            begin
               next_state = SBW_ADDR;
               next_beat = BEAT_ZERO;
            end
         end
         SBW_ADDR:
         begin
            if (addr_ok)
            begin
               // issued: data beats follow at once
               next_state = SBW_DATA;
               next_beat = FIRST_DATA;
            end
            else
            begin
               // not issued: present the same pair again
               next_state = SBW_DATA;
               next_beat = RETRY_BEAT;
            end
         end
         SBW_DATA:
         begin
            // retry data cycle over: offer the pair once more
            if (beat == RETRY_BEAT)
            begin
               next_state = can_start ? SBW_ADDR : SBW_IDLE;
               next_beat = BEAT_ZERO;
            end
            // walk the data beats in address order
            else if (!at_last)
               next_beat = beat + 4'h1;
            else
            begin
               next_hi_half = split && !hi_half;
               next_beat = BEAT_ZERO;
               if (use_gap)
               begin
                  next_state = SBW_GAP;
                  next_gap = 2'(LEGACY_IDLE - 1);
               end
               // the head leaves now unless its high half follows, so only that half or a request behind it counts
               else
                  next_state = pair_go(next_hi_half || more_queued, rdy_early) ? SBW_ADDR : SBW_IDLE;
            end
         end
         SBW_GAP:
         begin
            // two idle cycles, then the next pair if ready allows
            if (gap == 2'h0)
               next_state = pair_go(hi_half || fifo_valid, rdy_early) ? SBW_ADDR : SBW_IDLE;
            else
               next_gap = gap - 2'h1;
         end
         default:
            next_state = SBW_IDLE;
      endcase
   end
   assign fifo_pop = whole_end && (beat != RETRY_BEAT);

   // state and beat advance together
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state <= SBW_IDLE;
         beat <= BEAT_ZERO;
      end
      else
      begin
         state <= next_state;
         beat <= next_beat;
      end
   end
   // split half and idle count
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         hi_half <= 1'b0;
         gap <= 2'h0;
      end
      else
      begin
         hi_half <= next_hi_half;
         gap <= next_gap;
      end
   end

   // =========================================
   // registered pin drive, one cycle behind the sequencer state
   wire logic driving = (state == SBW_ADDR) || (state == SBW_DATA);
   // address or data word, loaded every cycle even while idle; zero only in reset
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         sys_addr_data_bus <= 64'h0000_0000_0000_0000;
      else
         sys_addr_data_bus <= cur_beat.ad;
   end

   // check bits travel with their word in the same cycle
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         sys_check_bits <= 8'h00;
      else
         sys_check_bits <= cur_beat.chk;
   end

   // command in the address cycle, data identifier after it
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         sys_command_bus <= 9'h000;
      else
         sys_command_bus <= cur_beat.cmd;
   end

   // valid strobe and lane enable move together
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         processor_drive_valid_n <= 1'b1;
         bus_oe_n <= 1'b1;
      end
      else
      begin
         processor_drive_valid_n <= !driving;
         bus_oe_n <= !driving;
      end
   end

   // one pulse per request that left the buffer
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         write_done <= 1'b0;
      else
         write_done <= fifo_pop;
   end
endmodule : sbw_write_path

// [sim/sbw_assertions.sv]
// assertion checker for the write path bus pins
`timescale 1ns/10ps
module sbw_checker
   import sbw_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic cfg_bus32,
   input wire logic [1:0] cfg_mode,
   input wire logic [63:0] sys_addr_data_bus,
   input wire logic [7:0] sys_check_bits,
   input wire logic [8:0] sys_command_bus,
   input wire logic processor_drive_valid_n,
   input wire logic bus_oe_n
);
   // =========================================
   // cycle kinds seen on the pins
   wire act = !processor_drive_valid_n;
   wire adr = act && !sys_command_bus[8];
   wire dat = act && sys_command_bus[8];
   wire more = dat && sys_command_bus[7];
   wire last = dat && !sys_command_bus[7];
   wire blk = adr && sys_command_bus[4:3] == WR_ATTR_BLOCK;
   wire [63:0] ad = sys_addr_data_bus;
   wire [3:0] par = {^ad[31:24], ^ad[23:16], ^ad[15:8], ^ad[7:0]};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // =========================================
   // assertions
   a_write_type: assert property (adr |-> sys_command_bus[7:5] == REQ_TYPE_WRITE)
      else $error("address cycle lacks write type");
   a_addr_data: assert property (adr |=> dat)
      else $error("address cycle not followed by data");
   a_data_ident: assert property (dat |-> sys_command_bus[6:0] == 7'h00)
      else $error("data identifier has stray bits");
   // a refused reissue cuts a block short, so that mode is left out
   a_block_four: assert property (blk && !cfg_bus32 && cfg_mode != 2'h1 |=> more [*3] ##1 last)
      else $error("64-bit block not four beats");
   a_block_eight: assert property (blk && cfg_bus32 && cfg_mode != 2'h1 |=> more [*7] ##1 last)
      else $error("32-bit block not eight beats");
   a_single_one: assert property (adr && !blk |=> last)
      else $error("single write not one beat");
   a_legacy_idle: assert property (last && cfg_mode == 2'h0 |=> processor_drive_valid_n [*2])
      else $error("legacy write lacks two idle cycles");
   a_addr_align: assert property (adr |-> (cfg_bus32 ? ad[1:0] == 2'h0 : ad[2:0] == 3'h0))
      else $error("write address misaligned");
   a_low_lanes: assert property (act && cfg_bus32 |-> ad[63:32] == 32'h0000_0000)
      else $error("upper lanes used in 32-bit mode");
   a_even_parity: assert property (act && cfg_bus32 |-> sys_check_bits[3:0] == par)
      else $error("check bits not even parity");
   a_oe_follows: assert property (bus_oe_n == processor_drive_valid_n)
      else $error("lane enable differs from valid strobe");
   c_block32: cover property (blk && cfg_bus32);
   c_block64: cover property (blk && !cfg_bus32);
   c_reissue: cover property (adr && cfg_mode == 2'h1);
   c_pipe_back: cover property (last && cfg_mode == 2'h2 ##1 adr);
endmodule : sbw_checker

bind sbw_write_path sbw_checker checker_i (.ref_clk, .sys_rst, .cfg_bus32, .cfg_mode, .sys_addr_data_bus,
   .sys_check_bits, .sys_command_bus, .processor_drive_valid_n, .bus_oe_n);

// [sim/sbw_agent.sv]
// far-side agent model: drives write ready and logs every bus cycle
`timescale 1ns/10ps
module sbw_agent
   import sbw_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic stall,
   input wire logic [63:0] sys_addr_data_bus,
   input wire logic [8:0] sys_command_bus,
   input wire logic processor_drive_valid_n,
   output logic write_accept_ready_n
);
   logic [63:0] addr_q[$];
   logic [63:0] data_q[$];
   // ready follows the commanded stall only; unlimited buffer, so nothing is dropped
   assign write_accept_ready_n = stall;
   // every presented pair is taken, the one after a deassert too
   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         addr_q.delete();
         data_q.delete();
      end
      else if (!processor_drive_valid_n && !sys_command_bus[8])
         addr_q.push_back(sys_addr_data_bus);
      else if (!processor_drive_valid_n)
         data_q.push_back(sys_addr_data_bus);
   end
endmodule : sbw_agent

// [sim/system_bus_write_path_test.sv]
// randomised self-checking bench for the system bus write path
`timescale 1ns/10ps
module system_bus_write_path_test
   import sbw_pkg::*;
;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cfg_bus32 = 1'b0;
   logic cfg_big_end = 1'b0;
   logic [1:0] cfg_mode = 2'h0;
   logic req_valid = 1'b0;
   sbw_req_s req_data = '0;
   logic stall = 1'b1;
   logic req_ready, write_accept_ready_n, processor_drive_valid_n, bus_oe_n, write_done;
   logic [63:0] sys_addr_data_bus;
   logic [7:0] sys_check_bits;
   logic [8:0] sys_command_bus;
   logic [63:0] exp_q[$];
   int errors = 0;
   int check_count = 0;
   int done_count = 0;
   // =========================================
   // clock, design and far-side agent
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (write_done === 1'b1) done_count++;
   sbw_write_path dut (.ref_clk, .sys_rst, .cfg_bus32, .cfg_big_end, .cfg_mode, .req_valid, .req_ready,
      .req_data, .write_accept_ready_n, .sys_addr_data_bus, .sys_check_bits, .sys_command_bus,
      .processor_drive_valid_n, .bus_oe_n, .write_done);
   sbw_agent agent (.ref_clk, .sys_rst, .stall, .sys_addr_data_bus, .sys_command_bus,
      .processor_drive_valid_n, .write_accept_ready_n);
   // =========================================
   // compare and finish
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] expv);
      check_count++;
      if (seen !== expv)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, expv, seen);
      end
   endtask : check
   task automatic complete_run;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   // =========================================
   // request offer, held until taken or four edges pass
   task automatic offer(input sbw_req_s r, output bit taken);
      logic ok;
      taken = 0;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_data <= r;
      repeat (4)
      begin
         @(negedge ref_clk);
         ok = req_ready;
         @(posedge ref_clk);
         if (ok === 1'b1)
         begin
            taken = 1;
            break;
         end
      end
      req_valid <= 1'b0;
      req_data <= ~r;
   endtask : offer
   // a doubleword goes out as two words on the narrow bus
   task automatic expect_dw(input logic [63:0] dw);
      if (!cfg_bus32)
         exp_q.push_back(dw);
      else
      begin
         exp_q.push_back({32'h0000_0000, cfg_big_end ? dw[63:32] : dw[31:0]});
         exp_q.push_back({32'h0000_0000, cfg_big_end ? dw[31:0] : dw[63:32]});
      end
   endtask : expect_dw
   // =========================================
   // one configuration: fill while stalled, then drain
   task automatic run_cfg(input logic b32, input logic [1:0] m);
      sbw_req_s r;
      logic [63:0] a0, a1;
      bit taken;
      int n, k;
      @(posedge ref_clk);
      stall <= 1'b1;
      sys_rst <= 1'b1;
      cfg_bus32 <= b32;
      cfg_mode <= m;
      cfg_big_end <= 1'($urandom);
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      exp_q.delete();
      done_count = 0;
      n = 0;
      taken = 1;
      // block first, a wide single next, then short singles until refused
      while (taken && n < 12)
      begin
         r.blk = (n == 0);
         r.addr = {32'h0000_0000, $urandom} & 64'hffff_ffff_ffff_ffe0;
         r.size = (n == 1) ? 3'h7 : 3'($urandom % 4);
         r.keep_line = 1'($urandom);
         for (int i = 0; i < 8; i++) r.line[32*i +: 32] = $urandom;
         offer(r, taken);
         if (taken)
         begin
            if (n == 0) a0 = r.addr;
            if (n == 1) a1 = r.addr;
            if (n < 2) for (int i = 0; i < 4 - 3 * n; i++) expect_dw(r.line[64*i +: 64]);
            n++;
         end
      end
      check("fifo fills", 64'(n >= FIFO_DEPTH && !taken), 64'h1);
      repeat (20) @(posedge ref_clk);
      check("held writes", 64'(agent.addr_q.size()), 64'h0);
      // stalls at random, except in reissue mode where a refusal repeats a pair
      k = 0;
      while (agent.data_q.size() < (b32 ? n + 8 : n + 3) && k < 800)
      begin
         @(posedge ref_clk);
         stall <= (m != 2'h1) && ($urandom % 4 == 0);
         k++;
      end
      @(posedge ref_clk);
      stall <= 1'b0;
      check("drain", 64'(k < 800), 64'h1);
      if (k >= 800) complete_run();
      repeat (10) @(posedge ref_clk);
      check("data count", 64'(agent.data_q.size()), 64'(b32 ? n + 8 : n + 3));
      check("addr count", 64'(agent.addr_q.size()), 64'(b32 ? n + 1 : n));
      check("done count", 64'(done_count), 64'(n));
      check("block addr", agent.addr_q[0], a0);
      check("wide addr", agent.addr_q[1], a1);
      if (b32) check("split addr", agent.addr_q[2], a1 + 64'h4);
      foreach (exp_q[i]) check("data word", agent.data_q[i], exp_q[i]);
   endtask : run_cfg
   // =========================================
   // both widths against every protocol
   initial
   begin
      void'($urandom(32'h5844_7307));
      for (int b = 0; b < 2; b++)
         for (int m = 0; m < 3; m++)
         begin
            run_cfg(1'(b), 2'(m));
            $display("test bus32 %0d mode %0d finished", b, m);
         end
      complete_run();
   end
endmodule : system_bus_write_path_test
